// File: hw/serial_mux_with_scan.sv
// Purpose: 32-to-1 two-stage serializer with loop mode and scan port
// Assumes: clk is the reference clock; pins are asynchronous
// Notes:   Scan clock is oversampled, so it must stay slow
// Operation
// - Split 32 channels into four groups of eight, each serialized 8:1.
// - Each group is a shift register loaded on the pulse, shifted at 625.
// - Sync unit makes the load pulse; two select pins move the capture phase.
// - Two 2:1 muxes then a third 2:1 mux merge into one stream.
// - Channel 31 goes out first as MSB, channel 0 last.
// - Loop enable low sends data to loopback outputs, else line outputs.
// - The unselected set of serial output buffers is switched off.
// - Reference clock divided to 78 MHz on the low-speed clock output.
// - Scan covers all low-speed pins but captureReady; every test except SAMPLE.
// - Two-bit instruction: 00 EXTEST, 01 preload, 10 IDCODE, 11 BYPASS.
// - Identification and boundary registers share one shift chain.
// - Identification shifts out LSB first, and that LSB is one.
// - Chain bits: 35 low clock, 34 loop, 33 sel2, 32 sel1, 31..0 data.
// - TAP controller and bypass register follow the standard.
// - Undriven scan inputs read as high.
// - Bit clock goes to loopback clock outputs in loop mode, else line.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Word FIFO between capture and load
// ****************************************
module sync_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,      // Reference clock
   input  wire logic             rst_b,    // Async reset, low
   input  wire logic             inValid,  // Word offered
   output logic                  inReady,  // Room for a word
   input  wire logic [WIDTH-1:0] inData,   // Word in
   output logic                  outValid, // Word available
   input  wire logic             outReady, // Word taken
   output logic      [WIDTH-1:0] outData   // Word out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr;
   logic [AW:0]      rdPtr;
   logic             full;
   logic             empty;

   // Extra pointer bit tells full from empty
   assign full     = (wrPtr[AW] != rdPtr[AW]) &&
                     (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
   assign empty    = (wrPtr == rdPtr);
   assign inReady  = !full;
   assign outValid = !empty;
   assign outData  = mem[rdPtr[AW-1:0]];

   // Pointers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         if (inValid && !full) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (outReady && !empty) begin
            rdPtr <= rdPtr + 1'b1;
         end
      end
   end

   // Storage needs no reset
   always_ff @(posedge clk) begin
      if (inValid && !full) begin
         mem[wrPtr[AW-1:0]] <= inData;
      end
   end
endmodule // sync_fifo

// ****************************************
// Top level
// ****************************************
module serial_mux_with_scan
   import serial_mux_pkg::*;
#(
   parameter logic [31:0] ID_CODE = ID_DEFAULT // Arbitrary value
) (
   input  wire logic          clk,                 // Reference clock
   input  wire logic          rst_b,               // Async reset, low
   input  wire logic [CHANNELS-1:0] parallelChannelIn, // Parallel data
   input  wire logic          loopEnableN,         // Loop mode, low
   input  wire logic          loadPhaseSelect1,    // Load phase sel 1
   input  wire logic          loadPhaseSelect2,    // Load phase sel 2
   output logic               lowSpeedClockOut,    // Divided clock
   output logic               captureReady,        // FIFO has room
   output logic               lineDataOut,         // Line data
   output logic               lineDataOutInv,      // Line data inv
   output logic               lineClockOut,        // Line clock
   output logic               lineClockOutInv,     // Line clock inv
   output logic               lineOutputOn,        // Line buffers on
   output logic               loopbackDataOut,     // Loop data
   output logic               loopbackDataOutInv,  // Loop data inv
   output logic               loopbackClockOut,    // Loop clock
   output logic               loopbackClockOutInv, // Loop clock inv
   output logic               loopbackOutputOn,    // Loop buffers on
   input  wire logic          testClock,           // Scan clock pin
   input  wire logic          testModeSelect,      // Scan mode select
   input  wire logic          testDataIn,          // Scan data in
   input  wire logic          testResetN,          // Scan reset, low
   output logic               testDataOut,         // Scan data out
   output logic               testDataOutOn        // Scan out enable
);
   typedef struct packed {
      logic [CHANNELS-1:0] data1;
      logic [CHANNELS-1:0] data2;
      logic [2:0]  ctl1;     // loop, sel2, sel1
      logic [2:0]  ctl2;
      logic [3:0]  tap1;     // reset, clock, mode, data
      logic [3:0]  tap2;
      logic        tckPrev;
      logic [DIV_W-1:0] divCount;
      logic        lowClk;
      logic [GROUPS-1:0][GROUP_BITS-1:0] grp;
      logic        lineData;
      logic        loopData;
      logic        bitClk;
      logic        lineOn;
      logic        loopOn;
      tap_type     tap;
      logic [1:0]  ir;
      logic [1:0]  irShift;
      logic [BSR_LEN-1:0] chain;
      logic [BSR_LEN-1:0] bsrOut;
      logic        bypass;
      logic        tdo;
      logic        tdoOn;
   } state_type;

   state_type st;
   state_type next_st;
   logic [CHANNELS-1:0] fifoData;
   logic      fifoValid;
   logic      captureNow;
   logic      loadNow;
   logic [DIV_W-1:0] capturePhase;
   // Sync unit: synced selects move the capture slot by quarters
   assign capturePhase = DIV_W'(st.ctl2[1:0]) * PHASE_STEP;
   assign captureNow   = (st.divCount == capturePhase);
   assign loadNow      = (st.divCount == DIV_LAST);
   // Decouples pin capture from the load pulse
   sync_fifo #(.WIDTH(CHANNELS), .DEPTH(FIFO_DEPTH)) wordFifo (
      .clk      (clk),
      .rst_b    (rst_b),
      .inValid  (captureNow),
      .inReady  (captureReady),
      .inData   (st.data2),
      .outValid (fifoValid),
      .outReady (loadNow),
      .outData  (fifoData)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic    tckRise, tckFall, tmsS, tdiS, loopMode;
      logic    g3, g2, g1, g0, muxA, muxB, serial;
      tap_type nt;
      next_st  = st;
      tckRise  = st.tap2[2] && !st.tckPrev;
      tckFall  = !st.tap2[2] && st.tckPrev;
      tmsS     = st.tap2[1];
      tdiS     = st.tap2[0];
      loopMode = !st.ctl2[2];
      nt       = st.tap;
      // Stage two: 2:1 pairs then final 2:1, MSB channel first
      g3       = st.grp[3][GROUP_BITS-1];
      g2       = st.grp[2][GROUP_BITS-1];
      g1       = st.grp[1][GROUP_BITS-1];
      g0       = st.grp[0][GROUP_BITS-1];
      muxA     = st.divCount[1] ? g1 : g3;
      muxB     = st.divCount[1] ? g0 : g2;
      serial   = st.divCount[0] ? muxB : muxA;
      // Two-stage pin synchronisers
      next_st.data1   = parallelChannelIn;
      next_st.data2   = st.data1;
      next_st.ctl1    = {loopEnableN, loadPhaseSelect2, loadPhaseSelect1};
      next_st.ctl2    = st.ctl1;
      next_st.tap1    = {testResetN, testClock, testModeSelect,
                         testDataIn};
      next_st.tap2    = st.tap1;
      next_st.tckPrev = st.tap2[2];
      // Divider: high for the first half of each word
      next_st.divCount = (st.divCount == DIV_LAST) ? '0
                         : st.divCount + 1'b1;
      next_st.lowClk   = (next_st.divCount < DIV_HALF);
      // Stage one: load on the pulse, else shift every fourth bit
      for (int g = 0; g < GROUPS; g++) begin
         if (loadNow) begin
            for (int j = 0; j < GROUP_BITS; j++) begin
               next_st.grp[g][j] = fifoValid ?
                  fifoData[j*GROUPS+g] : 1'b0;
            end
         end else if (st.divCount[1:0] == SHIFT_SLOT) begin
            next_st.grp[g] = {st.grp[g][GROUP_BITS-2:0], 1'b0};
         end
      end
      // Route by mode; idle set is held off
      next_st.lineOn   = !loopMode;
      next_st.loopOn   = loopMode;
      next_st.lineData = !loopMode && serial;
      next_st.loopData = loopMode && serial;
      next_st.bitClk   = !st.bitClk;
      // TAP controller, advanced on synced scan clock edges
      if (tckRise) begin
         case (st.tap)
            TLR:    nt = tmsS ? TLR    : RTI;
            RTI:    nt = tmsS ? SEL_DR : RTI;
            SEL_DR: nt = tmsS ? SEL_IR : CAP_DR;
            CAP_DR: nt = tmsS ? EX1_DR : SH_DR;
            SH_DR:  nt = tmsS ? EX1_DR : SH_DR;
            EX1_DR: nt = tmsS ? UPD_DR : PA_DR;
            PA_DR:  nt = tmsS ? EX2_DR : PA_DR;
            EX2_DR: nt = tmsS ? UPD_DR : SH_DR;
            UPD_DR: nt = tmsS ? SEL_DR : RTI;
            SEL_IR: nt = tmsS ? TLR    : CAP_IR;
            CAP_IR: nt = tmsS ? EX1_IR : SH_IR;
            SH_IR:  nt = tmsS ? EX1_IR : SH_IR;
            EX1_IR: nt = tmsS ? UPD_IR : PA_IR;
            PA_IR:  nt = tmsS ? EX2_IR : PA_IR;
            EX2_IR: nt = tmsS ? UPD_IR : SH_IR;
            default: nt = tmsS ? SEL_DR : RTI;
         endcase
         next_st.tap = nt;
         // Register actions in the state being left
         case (st.tap)
            TLR: begin
               next_st.ir = IR_IDCODE;
            end
            CAP_DR: begin
               if (st.ir == IR_BYPASS) begin
                  next_st.bypass = 1'b0;
               end else if (st.ir == IR_IDCODE) begin
                  next_st.chain[ID_LEN-1:0] = ID_CODE;
               end else begin
                  // Inputs and the divided clock as seen now
                  next_st.chain = {st.lowClk, st.ctl2,
                                   st.data2};
               end
            end
            SH_DR: begin
               if (st.ir == IR_BYPASS) begin
                  next_st.bypass = tdiS;
               end else if (st.ir == IR_IDCODE) begin
                  next_st.chain[ID_LEN-1:0] =
                     {tdiS, st.chain[ID_LEN-1:1]};
               end else begin
                  next_st.chain = {tdiS,
                                   st.chain[BSR_LEN-1:1]};
               end
            end
            UPD_DR: begin
               if (st.ir == IR_EXTEST || st.ir == IR_PRELOAD) begin
                  next_st.bsrOut = st.chain;
               end
            end
            CAP_IR: next_st.irShift = IR_CAPTURE;
            SH_IR:  next_st.irShift = {tdiS, st.irShift[1]};
            UPD_IR: next_st.ir = st.irShift;
            default: next_st.ir = st.ir;
         endcase
      end
      // Scan output changes on the falling edge
      if (tckFall) begin
         next_st.tdoOn = (st.tap == SH_DR) || (st.tap == SH_IR);
         if (st.tap == SH_IR) begin
            next_st.tdo = st.irShift[0];
         end else if (st.ir == IR_BYPASS) begin
            next_st.tdo = st.bypass;
         end else begin
            next_st.tdo = st.chain[0];
         end
      end
      // Scan reset pin forces the TAP state, instruction and scan output enable
      if (!st.tap2[3]) begin
         next_st.tap   = TLR;
         next_st.ir    = IR_IDCODE;
         next_st.tdoOn = 1'b0;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st      <= '0;
         st.ctl1 <= '1;
         st.ctl2 <= '1;
         st.tap1 <= '1;
         st.tap2 <= '1;
         st.tckPrev <= 1'b1;
         st.lowClk  <= 1'b1;
         st.ir      <= IR_IDCODE;
         st.tap     <= TLR;
         st.lineOn  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // EXTEST takes over the low-speed clock output pin
   assign lowSpeedClockOut = (st.ir == IR_EXTEST) ?
                             st.bsrOut[BSR_LOWCLK] : st.lowClk;
   assign lineDataOut         = st.lineData;
   assign lineDataOutInv      = st.lineOn && !st.lineData;
   assign loopbackDataOut     = st.loopData;
   assign loopbackDataOutInv  = st.loopOn && !st.loopData;
   // Bit clock to whichever set is live
   assign lineClockOut        = st.lineOn && st.bitClk;
   assign lineClockOutInv     = st.lineOn && !st.bitClk;
   assign loopbackClockOut    = st.loopOn && st.bitClk;
   assign loopbackClockOutInv = st.loopOn && !st.bitClk;
   assign lineOutputOn        = st.lineOn;
   assign loopbackOutputOn    = st.loopOn;
   assign testDataOut         = st.tdo;
   assign testDataOutOn       = st.tdoOn;
endmodule // serial_mux_with_scan

`default_nettype wire

// File: hw/serial_mux_pkg.sv
// Purpose: Shared constants and types of the serial mux with scan
// Assumes: clk is the high-speed reference, one line bit per period
// Notes:   Identification value is arbitrary
package serial_mux_pkg;
   // ****************************************
   // Datapath shape
   // ****************************************
   localparam int CHANNELS      = 32;
   localparam int GROUPS        = 4;
   localparam int GROUP_BITS    = 8;
   localparam int LINE_RATE_MBS = 2500;
   localparam int LOW_RATE_MBS  = 78;
   localparam int DIV_RATIO     = LINE_RATE_MBS / LOW_RATE_MBS;
   localparam int DIV_W         = $clog2(DIV_RATIO);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_RATIO - 1);
   localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(DIV_RATIO / 2);
   localparam logic [DIV_W-1:0] PHASE_STEP = DIV_W'(DIV_RATIO / 4);
   localparam logic [1:0]       SHIFT_SLOT = 2'h3;
   localparam int FIFO_DEPTH    = 4;
   // ****************************************
   // Scan
   // ****************************************
   localparam int TCK_MAX_MHZ = 12;
   localparam int BSR_LEN     = 36;
   localparam int ID_LEN      = 32;
   localparam int BSR_LOWCLK  = 35;
   localparam int BSR_LOOP    = 34;
   localparam int BSR_SEL2    = 33;
   localparam int BSR_SEL1    = 32;
   localparam logic [1:0] IR_EXTEST  = 2'h0;
   localparam logic [1:0] IR_PRELOAD = 2'h1;
   localparam logic [1:0] IR_IDCODE  = 2'h2;
   localparam logic [1:0] IR_BYPASS  = 2'h3;
   localparam logic [1:0] IR_CAPTURE = 2'h1;
   // Arbitrary identification value; LSB must stay 1
   localparam logic [31:0] ID_DEFAULT = 32'h0000_5a01;
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } tap_type;
endpackage

// File: tb/serial_mux_properties.sv
// Purpose: Port timing checks of the serial mux with scan
// Assumes: One clock domain, async reset rst_b
// Notes:   Period checks assume the divided clock is never scan-driven
`timescale 1ns/1ps
`default_nettype none
module serial_mux_properties (
   input wire logic clk,                 // Reference clock
   input wire logic rst_b,               // Async reset, low
   input wire logic loopEnableN,         // Loop mode, low
   input wire logic testResetN,          // Scan reset, low
   input wire logic lowSpeedClockOut,    // Divided clock
   input wire logic lineDataOut,         // Line data
   input wire logic lineDataOutInv,      // Line data inv
   input wire logic lineClockOut,        // Line clock
   input wire logic lineClockOutInv,     // Line clock inv
   input wire logic lineOutputOn,        // Line buffers on
   input wire logic loopbackDataOut,     // Loop data
   input wire logic loopbackDataOutInv,  // Loop data inv
   input wire logic loopbackClockOut,    // Loop clock
   input wire logic loopbackClockOutInv, // Loop clock inv
   input wire logic loopbackOutputOn,    // Loop buffers on
   input wire logic testDataOutOn        // Scan out enable
);
   logic [2:0] upCnt;   // Clocks since reset, saturating
   logic [5:0] lowCnt;  // Clocks since divided clock rose
   logic       lowSeen; // One rise already seen
   logic       prevLow; // Divided clock one clock ago
   logic       ready;   // Outputs past their reset settling
   assign ready = (upCnt == 3'h7);
   // Helpers; the first high phase after reset is not timed
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         upCnt   <= 3'h0;
         lowCnt  <= 6'h0;
         lowSeen <= 1'b0;
         prevLow <= 1'b1;
      end else begin
         upCnt   <= ready ? upCnt : upCnt + 3'h1;
         lowCnt  <= (lowSpeedClockOut && !prevLow) ? 6'h1 : lowCnt + 6'h1;
         lowSeen <= lowSeen || (lowSpeedClockOut && !prevLow);
         prevLow <= lowSpeedClockOut;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_mode_loop: assert property (
      (!loopEnableN)[*5] |-> loopbackOutputOn && !lineOutputOn)
      else $error("loop mode not selected");
   chk_mode_line: assert property (
      loopEnableN[*5] |-> lineOutputOn && !loopbackOutputOn)
      else $error("normal mode not selected");
   chk_line_quiet: assert property (
      !lineOutputOn |-> !(lineDataOut || lineDataOutInv
                          || lineClockOut || lineClockOutInv))
      else $error("line outputs active while off");
   chk_loop_quiet: assert property (
      !loopbackOutputOn |-> !(loopbackDataOut || loopbackDataOutInv
                              || loopbackClockOut || loopbackClockOutInv))
      else $error("loop outputs active while off");
   chk_line_pair: assert property (
      ready && lineOutputOn && $past(lineOutputOn) |->
      lineDataOutInv == !lineDataOut && lineClockOutInv == !lineClockOut)
      else $error("line pair not complementary");
   chk_loop_pair: assert property (
      ready && loopbackOutputOn && $past(loopbackOutputOn) |->
      loopbackDataOutInv == !loopbackDataOut
      && loopbackClockOutInv == !loopbackClockOut)
      else $error("loop pair not complementary");
   chk_bit_clock: assert property (
      ready && $stable(lineOutputOn) && $stable(loopbackOutputOn) |->
      (lineClockOut ^ loopbackClockOut)
      != $past(lineClockOut ^ loopbackClockOut))
      else $error("bit clock missed a toggle");
   chk_low_period: assert property (
      lowSeen && lowSpeedClockOut && !prevLow |-> lowCnt == 6'h20)
      else $error("divided clock period wrong");
   chk_low_width: assert property (
      lowSeen && !lowSpeedClockOut && prevLow |-> lowCnt == 6'h10)
      else $error("divided clock high time wrong");
   chk_tdo_reset: assert property (
      (!testResetN)[*4] |-> !testDataOutOn)
      else $error("scan output on during test reset");
endmodule // serial_mux_properties
`default_nettype wire

// File: tb/tx_frame_model.sv
// Purpose: Transmit framing logic feeding the parallel channels
// Assumes: Words change just after the divided clock rises
// Notes:   Holds its last word while stopped
`timescale 1ns/1ps
`default_nettype none
module tx_frame_model (
   input  wire logic        clk,      // Reference clock
   input  wire logic        rst_b,    // Async reset, low
   input  wire logic        lowClock, // Divided clock from device
   input  wire logic        run,      // Send fresh words
   output logic      [31:0] word,     // Parallel channels
   output logic             sent      // Fresh word this clock
);
   integer seed;    // Random seed
   logic   lastLow; // Divided clock one clock ago
   initial seed = 17;
   // New word right after the rise keeps it stable at every phase
   always @(negedge clk or negedge rst_b) begin
      if (!rst_b) begin
         word    <= 32'h0;
         sent    <= 1'b0;
         lastLow <= 1'b1;
      end else begin
         sent <= run && lowClock && !lastLow;
         if (run && lowClock && !lastLow) begin
            word <= $random(seed);
         end
         lastLow <= lowClock;
      end
   end
endmodule // tx_frame_model
`default_nettype wire

// File: tb/serial_mux_with_scan_tb_top.sv
// Purpose: Self-checking bench of the serial mux with scan
// Assumes: Capture phase selects change only between streams
// Notes:   Stream checked by matching sent words in the serial bits
`timescale 1ns/1ps
`default_nettype none
module serial_mux_with_scan_tb_top;
   import serial_mux_pkg::*;
   localparam logic [31:0] IdValue = 32'h1234_5671; // Arbitrary, LSB 1
   logic clk, rst_b, loopEnableN, run, txSent, lowClk, armed;
   logic tck, tms, tdi, trstN, tdo, lineD, lineDI, lineC, lineCI, lineOn;
   logic loopD, loopDI, loopC, loopCI, loopOn;
   logic sel1, sel2, capReady, tdoOn;
   logic [31:0] txWord, win;
   logic [63:0] got;
   logic [31:0] sentQ[$];
   int n_fail, checked, gap;
   serial_mux_with_scan #(.ID_CODE(IdValue)) DUT (
      .clk(clk), .rst_b(rst_b), .parallelChannelIn(txWord),
      .loopEnableN(loopEnableN), .loadPhaseSelect1(sel1),
      .loadPhaseSelect2(sel2), .lowSpeedClockOut(lowClk),
      .captureReady(capReady), .lineDataOut(lineD), .lineDataOutInv(lineDI),
      .lineClockOut(lineC), .lineClockOutInv(lineCI), .lineOutputOn(lineOn),
      .loopbackDataOut(loopD), .loopbackDataOutInv(loopDI),
      .loopbackClockOut(loopC), .loopbackClockOutInv(loopCI),
      .loopbackOutputOn(loopOn), .testClock(tck), .testModeSelect(tms),
      .testDataIn(tdi), .testResetN(trstN), .testDataOut(tdo),
      .testDataOutOn(tdoOn));
   tx_frame_model partner (.clk(clk), .rst_b(rst_b), .lowClock(lowClk),
      .run(run), .word(txWord), .sent(txSent));
   always #2.5 clk = ~clk;
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Reference model: each sent word must show up whole, 32 bits apart
   always @(negedge clk) begin
      if (txSent) sentQ.push_back(txWord);
      win = {win[30:0], loopOn ? loopD : lineD};
      gap = gap + 1;
      if (sentQ.size() > 0 && win === sentQ[0]) begin
         if (armed) check(64'(gap), 64'd32);
         void'(sentQ.pop_front());
         armed = 1'b1;
         gap = 0;
      end
   end
   // One test clock, slow enough for the scan port
   task automatic pulse(input logic m, input logic d, output logic o);
      @(negedge clk) tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (9) @(negedge clk);
      o = tdo;
      tck = 1'b1;
      repeat (9) @(negedge clk);
   endtask
   // From idle: select, capture, shift n bits, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [63:0] di,
                       output logic [63:0] dout);
      logic o;
      pulse(1'b1, 1'b0, o);
      if (ir) pulse(1'b1, 1'b0, o);
      pulse(1'b0, 1'b0, o);
      pulse(1'b0, 1'b0, o);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         pulse(i == n - 1, di[i], o);
         dout[i] = o;
      end
      pulse(1'b1, 1'b0, o);
      pulse(1'b0, 1'b0, o);
   endtask
   // Stream phase in the current mode
   task automatic stream;
      armed = 1'b0;
      repeat (128) @(negedge clk);
      run = 1'b1;
      repeat (640) @(negedge clk);
      run = 1'b0;
      repeat (128) @(negedge clk);
      check(64'(sentQ.size()), 64'd0);
      check(capReady, 1'b1);
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      complete_run;
   end
   initial begin
      clk = 0; rst_b = 0; loopEnableN = 1; run = 0; armed = 0; gap = 0;
      tck = 1; tms = 1; tdi = 1; trstN = 1; win = '0;
      sel2 = 1'b1;
      sel1 = 1'b0;
      n_fail = 0; checked = 0;
      repeat (5) @(negedge clk);
      rst_b = 1;
      stream();
      loopEnableN = 1'b0;
      sel1 = 1'b1;
      stream();
      loopEnableN = 1'b1;
      sel2 = 1'b0;
      sel1 = 1'b0;
      stream();
      pulse(1'b0, 1'b0, tdi);
      scan(1'b0, 32, 64'h0, got);
      check(got[31:0], IdValue);
      check(got[0], 1'b1);
      scan(1'b1, 2, 64'h3, got);
      check(got[1:0], IR_CAPTURE);
      scan(1'b0, 8, 64'ha5, got);
      check(got[7:0], 8'h4a);
      // Park in Shift-DR so the scan reset has a live output to kill
      pulse(1'b1, 1'b0, tdi);
      pulse(1'b0, 1'b0, tdi);
      pulse(1'b0, 1'b0, tdi);
      pulse(1'b0, 1'b0, tdi);
      check(tdoOn, 1'b1);
      trstN = 1'b0;
      repeat (6) @(negedge clk);
      check(tdoOn, 1'b0);
      trstN = 1'b1;
      repeat (4) @(negedge clk);
      pulse(1'b0, 1'b0, tdi);
      scan(1'b0, 32, 64'h0, got);
      check(got[31:0], IdValue);
      scan(1'b1, 2, 64'(IR_PRELOAD), got);
      scan(1'b0, 36, 64'h0, got);
      check(got[34:0], {loopEnableN, sel2, sel1, txWord});
      scan(1'b1, 2, 64'(IR_IDCODE), got);
      scan(1'b0, 32, 64'h0, got);
      check(got[31:0], IdValue);
      complete_run;
   end
endmodule // serial_mux_with_scan_tb_top
bind serial_mux_with_scan serial_mux_properties chk (
   .clk(clk), .rst_b(rst_b), .loopEnableN(loopEnableN),
   .testResetN(testResetN), .lowSpeedClockOut(lowSpeedClockOut),
   .lineDataOut(lineDataOut), .lineDataOutInv(lineDataOutInv),
   .lineClockOut(lineClockOut), .lineClockOutInv(lineClockOutInv),
   .lineOutputOn(lineOutputOn), .loopbackDataOut(loopbackDataOut),
   .loopbackDataOutInv(loopbackDataOutInv),
   .loopbackClockOut(loopbackClockOut),
   .loopbackClockOutInv(loopbackClockOutInv),
   .loopbackOutputOn(loopbackOutputOn), .testDataOutOn(testDataOutOn));
`default_nettype wire
